/* File: rtl/ntbpm_pkg.sv */
// package of offsets, field positions and reset values for the power regs
package ntbpm_pkg;

	// ==========================================================
	// register byte addresses
	localparam logic [11:0] NTBPM_CAP_OFFSET   = 12'h0f0;
	localparam logic [11:0] NTBPM_CSR_OFFSET   = 12'h0f4;
	localparam logic [11:0] NTBPM_LOCK_OFFSET  = 12'h0f8;

	// ==========================================================
	// capability fields
	localparam int NTBPM_CAPID_LSB      = 0;
	localparam int NTBPM_NEXT_LSB       = 8;
	localparam int NTBPM_VER_LSB        = 16;
	localparam int NTBPM_SPECIAL_POS    = 21;
	localparam int NTBPM_AUX_LSB        = 22;
	localparam int NTBPM_D1_POS         = 25;
	localparam int NTBPM_D2_POS         = 26;
	localparam int NTBPM_PME_LSB        = 27;
	localparam logic [7:0] NTBPM_CAPID_VAL = 8'h01;
	localparam logic [7:0] NTBPM_NEXT_VAL  = 8'h00;
	localparam logic [2:0] NTBPM_VER_VAL   = 3'h2;
	localparam logic       NTBPM_SPECIAL_RST = 1'b0;

	// ==========================================================
	// control and status fields
	localparam int NTBPM_PWR_STATE_LSB  = 0;
	localparam int NTBPM_EVT_EN_POS     = 8;
	localparam int NTBPM_DATA_SEL_LSB   = 9;
	localparam int NTBPM_DATA_SCALE_LSB = 13;
	localparam int NTBPM_EVT_ST_POS     = 15;
	localparam int NTBPM_BUS_LOW_POS    = 22;
	localparam int NTBPM_BPCC_POS       = 23;
	localparam int NTBPM_DATA_LSB       = 24;

	// power state codes
	typedef enum logic [1:0] {
		NTBPM_D0    = 2'h0,
		NTBPM_D1    = 2'h1,
		NTBPM_D2    = 2'h2,
		NTBPM_D3HOT = 2'h3
	} ntbpm_pwr_state_type;
	localparam logic [1:0] NTBPM_PWR_STATE_RST = 2'h0;

	// ==========================================================
	// bus response codes
	localparam logic [1:0] NTBPM_RESP_OKAY   = 2'h0;
	localparam logic [1:0] NTBPM_RESP_SLVERR = 2'h2;

endpackage : ntbpm_pkg

/* File: rtl/ntbpm_field_reg.sv */
// small writable field register with a single write enable
module ntbpm_field_reg
#(
	parameter int          WIDTH = 2,
	parameter logic [WIDTH-1:0] RESET = '0
)
(
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             wr_en,
	input  wire logic [WIDTH-1:0] wr_val,
	output      logic [WIDTH-1:0] val_q
);

	logic [WIDTH-1:0] val_d;

	// ==========================================================
	// next value
	always_comb
	begin
		val_d = val_q;
		if (wr_en)
		begin
			val_d = wr_val;
		end
	end

	// storage
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			val_q <= RESET;
		end
		else
		begin
			val_q <= val_d;
		end
	end

endmodule : ntbpm_field_reg

/* File: rtl/ntbpm_regs.sv */
// power management capability and control/status registers, axi4-lite slave
module ntbpm_regs
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	// write address channel
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output      logic        s_axi_awready,
	// write data channel
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output      logic        s_axi_wready,
	// write response channel
	output      logic [1:0]  s_axi_bresp,
	output      logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// read address channel
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output      logic        s_axi_arready,
	// read data channel
	output      logic [31:0] s_axi_rdata,
	output      logic [1:0]  s_axi_rresp,
	output      logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// current power state for the rest of the endpoint
	output      logic [1:0]  power_state_field
);

	// ==========================================================
	// write channel capture
	logic        aw_held_q, aw_held_d;
	logic [11:0] aw_addr_q, aw_addr_d;
	logic        w_held_q,  w_held_d;
	logic [31:0] w_data_q,  w_data_d;
	logic [3:0]  w_strb_q,  w_strb_d;
	logic        bvalid_q,  bvalid_d;
	logic [1:0]  bresp_q,   bresp_d;
	logic        awready_q, awready_d;
	logic        wready_q,  wready_d;
	logic        do_write;
	logic        write_hit;

	// readies are registered so every port leaves from a flop
	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign do_write      = aw_held_q & w_held_q & ~bvalid_q;

	// write side next values
	always_comb
	begin
		aw_held_d = aw_held_q;
		aw_addr_d = aw_addr_q;
		w_held_d  = w_held_q;
		w_data_d  = w_data_q;
		w_strb_d  = w_strb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_held_d = 1'b1;
			w_data_d = s_axi_wdata;
			w_strb_d = s_axi_wstrb;
		end
		if (do_write)
		begin
			aw_held_d = 1'b0;
			w_held_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = write_hit ? ntbpm_pkg::NTBPM_RESP_OKAY
			                      : ntbpm_pkg::NTBPM_RESP_SLVERR;
		end
		else if (bvalid_q && s_axi_bready)
		begin
			bvalid_d = 1'b0;
		end
		// each ready only while its own channel holds nothing and no answer is pending, so one write is in flight
		awready_d = ~aw_held_d & ~bvalid_d;
		wready_d  = ~w_held_d & ~bvalid_d;
	end

	// write side registers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_held_q <= 1'b0;
			aw_addr_q <= 12'h000;
			w_held_q  <= 1'b0;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= 2'h0;
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
		end
		else
		begin
			aw_held_q <= aw_held_d;
			aw_addr_q <= aw_addr_d;
			w_held_q  <= w_held_d;
			w_data_q  <= w_data_d;
			w_strb_q  <= w_strb_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			awready_q <= awready_d;
			wready_q  <= wready_d;
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;

	// ==========================================================
	// write decode
	logic [9:0] wr_word;
	logic       wr_cap, wr_csr, wr_lock;
	assign wr_word   = aw_addr_q[11:2];
	assign wr_cap    = (wr_word == ntbpm_pkg::NTBPM_CAP_OFFSET[11:2]);
	assign wr_csr    = (wr_word == ntbpm_pkg::NTBPM_CSR_OFFSET[11:2]);
	assign wr_lock   = (wr_word == ntbpm_pkg::NTBPM_LOCK_OFFSET[11:2]);
	assign write_hit = wr_cap | wr_csr | wr_lock;

	// ==========================================================
	// special-init bit with its write lock
	logic special_init_needed;
	logic special_lock_q;
	logic special_lock_d;
	logic special_wr;

	// lock is sticky until reset: once set the capability bit is frozen
	always_comb
	begin
		special_lock_d = special_lock_q;
		if (do_write && wr_lock && w_strb_q[0] && w_data_q[0])
		begin
			special_lock_d = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			special_lock_q <= 1'b0;
		end
		else
		begin
			special_lock_q <= special_lock_d;
		end
	end

	assign special_wr = do_write & wr_cap & w_strb_q[2] & ~special_lock_q;

	// resets to zero: no extra initialisation step is asked of software
	ntbpm_field_reg
	#(
		.WIDTH (1),
		.RESET (ntbpm_pkg::NTBPM_SPECIAL_RST)
	)
	u_special
	(
		.clk    (clk),
		.rst_n  (rst_n),
		.wr_en  (special_wr),
		.wr_val (w_data_q[ntbpm_pkg::NTBPM_SPECIAL_POS]),
		.val_q  (special_init_needed)
	);

	// ==========================================================
	// power state field
	logic [1:0] pwr_q;
	logic [1:0] pwr_wr_val;
	logic       pwr_legal;
	logic       pwr_wr;

	assign pwr_wr_val = w_data_q[ntbpm_pkg::NTBPM_PWR_STATE_LSB +: 2];
	// codes for d1 and d2 are reserved, so a write of them is dropped
	assign pwr_legal  = (pwr_wr_val == ntbpm_pkg::NTBPM_D0) ||
	                    (pwr_wr_val == ntbpm_pkg::NTBPM_D3HOT);
	assign pwr_wr     = do_write & wr_csr & w_strb_q[0] &
	                    pwr_legal;

	ntbpm_field_reg
	#(
		.WIDTH (2),
		.RESET (ntbpm_pkg::NTBPM_PWR_STATE_RST)
	)
	u_pwr_state
	(
		.clk    (clk),
		.rst_n  (rst_n),
		.wr_en  (pwr_wr),
		.wr_val (pwr_wr_val),
		.val_q  (pwr_q)
	);

	assign power_state_field = pwr_q;

	// ==========================================================
	// read images; every bit not placed here is hardwired zero
	logic [31:0] cap_image;
	logic [31:0] csr_image;
	logic [31:0] lock_image;

	always_comb
	begin
		cap_image = 32'h0000_0000;
		cap_image[ntbpm_pkg::NTBPM_CAPID_LSB +: 8] =
			ntbpm_pkg::NTBPM_CAPID_VAL;
		cap_image[ntbpm_pkg::NTBPM_NEXT_LSB +: 8] = ntbpm_pkg::NTBPM_NEXT_VAL;
		cap_image[ntbpm_pkg::NTBPM_VER_LSB +: 3]  = ntbpm_pkg::NTBPM_VER_VAL;
		cap_image[ntbpm_pkg::NTBPM_SPECIAL_POS]   = special_init_needed;
		// event enable/status, data fields and bus bits stay zero
		csr_image = 32'h0000_0000;
		csr_image[ntbpm_pkg::NTBPM_PWR_STATE_LSB +: 2] = pwr_q;
		csr_image[ntbpm_pkg::NTBPM_BUS_LOW_POS] = 1'b0;
		csr_image[ntbpm_pkg::NTBPM_BPCC_POS] = 1'b0;
		lock_image    = 32'h0000_0000;
		lock_image[0] = special_lock_q;
	end

	// ==========================================================
	// read channel
	logic        rvalid_q, rvalid_d;
	logic        arready_q, arready_d;
	logic [31:0] rdata_q,  rdata_d;
	logic [1:0]  rresp_q,  rresp_d;
	logic [9:0]  rd_word;

	assign s_axi_arready = arready_q;
	assign rd_word       = s_axi_araddr[11:2];

	// one read in flight; data registered on the accept edge
	always_comb
	begin
		rvalid_d = rvalid_q;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_d = 1'b1;
			rresp_d  = ntbpm_pkg::NTBPM_RESP_OKAY;
			if (rd_word == ntbpm_pkg::NTBPM_CAP_OFFSET[11:2])
			begin
				rdata_d = cap_image;
			end
			else if (rd_word == ntbpm_pkg::NTBPM_CSR_OFFSET[11:2])
			begin
				rdata_d = csr_image;
			end
			else if (rd_word == ntbpm_pkg::NTBPM_LOCK_OFFSET[11:2])
			begin
				rdata_d = lock_image;
			end
			else
			begin
				rdata_d = 32'h0000_0000;
				rresp_d = ntbpm_pkg::NTBPM_RESP_SLVERR;
			end
		end
		else if (rvalid_q && s_axi_rready)
		begin
			rvalid_d = 1'b0;
		end
		// no new address while an answer is still pending
		arready_d = ~rvalid_d;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= 2'h0;
		end
		else
		begin
			rvalid_q <= rvalid_d;
			arready_q <= arready_d;
			rdata_q  <= rdata_d;
			rresp_q  <= rresp_d;
		end
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;

endmodule : ntbpm_regs

/* File: verif/ntbpm_regs_checker.sv */
// concurrent checks on the power register bank ports
module ntbpm_regs_checker
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [1:0]  power_state_field
);
	timeunit 1ns;
	timeprecision 1ps;
	// =========================================================
	// address of the read in flight, so rdata can be judged
	logic [11:0] ra_q;
	logic [11:0] ra_d;
	always_comb
	begin
		ra_d = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : ra_q;
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ra_q <= 12'h000;
		else
			ra_q <= ra_d;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// =========================================================
	// properties
	property p_pst_legal;
		power_state_field != 2'h1 && power_state_field != 2'h2;
	endproperty
	a_pst_legal: assert property (p_pst_legal)
		else $error("power state holds a reserved code");
	property p_pst_commit;
		$changed(power_state_field) |-> $rose(s_axi_bvalid);
	endproperty
	a_pst_commit: assert property (p_pst_commit)
		else $error("power state moved without a write");
	property p_csr_ro;
		s_axi_rvalid && ra_q == 12'h0f4 |-> s_axi_rdata[31:2] == '0;
	endproperty
	a_csr_ro: assert property (p_csr_ro)
		else $error("read-only control bits not zero");
	property p_cap_ro;
		s_axi_rvalid && ra_q == 12'h0f0 |-> s_axi_rdata[31:22] == '0;
	endproperty
	a_cap_ro: assert property (p_cap_ro)
		else $error("capability upper bits not zero");
	property p_rd_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read not answered next cycle");
	property p_rd_hold;
		s_axi_rvalid && !s_axi_rready |=>
			s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read answer dropped early");
	property p_wr_answer;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|-> ##[1:2] s_axi_bvalid;
	endproperty
	a_wr_answer: assert property (p_wr_answer)
		else $error("write not answered in time");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write answer dropped early");
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block)
		else $error("second read taken while one is pending");
endmodule : ntbpm_regs_checker

bind ntbpm_regs ntbpm_regs_checker i_chk
(
	.clk               (clk),
	.rst_n             (rst_n),
	.s_axi_awvalid     (s_axi_awvalid),
	.s_axi_awready     (s_axi_awready),
	.s_axi_wvalid      (s_axi_wvalid),
	.s_axi_wready      (s_axi_wready),
	.s_axi_bresp       (s_axi_bresp),
	.s_axi_bvalid      (s_axi_bvalid),
	.s_axi_bready      (s_axi_bready),
	.s_axi_araddr      (s_axi_araddr),
	.s_axi_arvalid     (s_axi_arvalid),
	.s_axi_arready     (s_axi_arready),
	.s_axi_rdata       (s_axi_rdata),
	.s_axi_rresp       (s_axi_rresp),
	.s_axi_rvalid      (s_axi_rvalid),
	.s_axi_rready      (s_axi_rready),
	.power_state_field (power_state_field)
);

/* File: verif/tb.sv */
// self-checking bench for the power register bank
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'h0;
	logic        rst_n = 1'h0;
	logic [11:0] s_axi_awaddr = '0;
	logic [11:0] s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0]  s_axi_wstrb = '0;
	logic        s_axi_awvalid = 1'h0;
	logic        s_axi_wvalid = 1'h0;
	logic        s_axi_arvalid = 1'h0;
	logic        s_axi_bready = 1'h1; // answers are always accepted
	logic        s_axi_rready = 1'h1;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, power_state_field;
	logic [31:0] s_axi_rdata;
	int          n_mismatch = 0;
	int          checks = 0;
	// model state: power state, lock, special-init bit
	int          pst, lck, b21;
	ntbpm_regs i_dut
	(
		.clk               (clk),
		.rst_n             (rst_n),
		.s_axi_awaddr      (s_axi_awaddr),
		.s_axi_awvalid     (s_axi_awvalid),
		.s_axi_awready     (s_axi_awready),
		.s_axi_wdata       (s_axi_wdata),
		.s_axi_wstrb       (s_axi_wstrb),
		.s_axi_wvalid      (s_axi_wvalid),
		.s_axi_wready      (s_axi_wready),
		.s_axi_bresp       (s_axi_bresp),
		.s_axi_bvalid      (s_axi_bvalid),
		.s_axi_bready      (s_axi_bready),
		.s_axi_araddr      (s_axi_araddr),
		.s_axi_arvalid     (s_axi_arvalid),
		.s_axi_arready     (s_axi_arready),
		.s_axi_rdata       (s_axi_rdata),
		.s_axi_rresp       (s_axi_rresp),
		.s_axi_rvalid      (s_axi_rvalid),
		.s_axi_rready      (s_axi_rready),
		.power_state_field (power_state_field)
	);
	always #4 clk = ~clk;
	// =========================================================
	// model and compare
	function automatic logic [31:0] ev(input logic [11:0] a);
		case (a)
			12'h0f0: return 32'h0002_0001 | (32'(b21) << 21);
			12'h0f4: return 32'(pst);
			12'h0f8: return 32'(lck);
			default: return '0;
		endcase
	endfunction : ev
	function automatic logic [1:0] er(input logic [11:0] a);
		return (a inside {12'h0f0, 12'h0f4, 12'h0f8}) ? 2'h0 : 2'h2;
	endfunction : er
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		begin
			checks++;
			if (seen !== exp)
			begin
				n_mismatch++;
				$display("FAIL %s exp %h seen %h", nm, exp, seen);
			end
		end
	endtask : chk
	// =========================================================
	// bus tasks: ready sampled mid-cycle, released after the edge
	task automatic rm(input logic [11:0] a);
		logic t, v;
		logic [31:0] d;
		logic [1:0] r;
		begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'h1;
			v = 1'h0;
			while (!v)
			begin
				@(negedge clk);
				t = s_axi_arvalid && s_axi_arready;
				v = s_axi_rvalid;
				d = s_axi_rdata;
				r = s_axi_rresp;
				@(posedge clk);
				if (t)
					s_axi_arvalid <= 1'h0;
			end
			chk("rdata", d, ev(a));
			chk("rresp", 32'(r), 32'(er(a)));
		end
	endtask : rm
	task automatic mw(input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		logic ta, tw, v;
		begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_wstrb <= s;
			s_axi_awvalid <= 1'h1;
			s_axi_wvalid <= 1'h1;
			v = 1'h0;
			while (!v)
			begin
				@(negedge clk);
				ta = s_axi_awvalid && s_axi_awready;
				tw = s_axi_wvalid && s_axi_wready;
				v = s_axi_bvalid;
				if (v)
					chk("bresp", 32'(s_axi_bresp), 32'(er(a)));
				@(posedge clk);
				if (ta)
					s_axi_awvalid <= 1'h0;
				if (tw)
					s_axi_wvalid <= 1'h0;
			end
			if (a == 12'h0f4 && s[0] && (d[1:0] == 2'h0 || d[1:0] == 2'h3))
				pst = d[1:0];
			if (a == 12'h0f0 && s[2] && lck == 0)
				b21 = d[21];
			if (a == 12'h0f8 && s[0] && d[0])
				lck = 1;
			rm(a);
			chk("power_state_field", 32'(power_state_field), 32'(pst));
		end
	endtask : mw
	// reset, then every word read against its reset value
	task automatic rst_chk;
		begin
			rst_n <= 1'h0;
			pst = 0;
			lck = 0;
			b21 = 0;
			repeat (20) @(posedge clk);
			rst_n <= 1'h1;
			@(posedge clk);
			for (int i = 0; i < 4; i++)
				rm(12'h0f0 + 12'(4 * i));
			chk("power_state_field", 32'(power_state_field), 32'h0000_0000);
		end
	endtask : rst_chk
	task automatic print_verdict;
		begin
			$display("checks %0d mismatches %0d", checks, n_mismatch);
			if (n_mismatch == 0 && checks > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask : print_verdict
	// =========================================================
	// main sequence
	initial
	begin
		void'($urandom(20));
		@(posedge clk);
		rst_chk();
		// codes 0,3,2,1 twice: reserved ones are written only while the state is d3hot
		for (int i = 0; i < 8; i++)
			mw(12'h0f4, ($urandom() & 32'hffff_fffc) |
				32'((i * 3) % 4), 4'hf);
		mw(12'h0f4, 32'h0000_0000, 4'he);
		mw(12'h0f0, $urandom() | 32'h0020_0000, 4'hf);
		mw(12'h0f8, 32'h0000_0001, 4'hf);
		mw(12'h0f0, 32'h0000_0000, 4'hf);
		for (int i = 0; i < 12; i++)
			mw(12'h0f0 + 12'($urandom_range(4) * 4), $urandom(),
				4'($urandom()));
		rst_chk();
		print_verdict();
	end
	// watchdog: the run needs well under a thousand cycles
	initial
	begin
		#40000;
		n_mismatch++;
		print_verdict();
	end
endmodule : tb
